// ---- common/cesr_consts.svh ----
// constants for the cpu error status report block
`ifndef CESR_CONSTS_SVH
`define CESR_CONSTS_SVH
`define CESR_NUM_CPU 4
`define CESR_EVT_W 58
`define CESR_DEF_W 7
`define CESR_PAR_W 8
`define CESR_FPSTAT_W 32
`define CESR_FPSTAT_QC 27
`define CESR_FPSTAT_IDC 7
`define CESR_DEF_QC 6
`define CESR_DEF_IDC 5
`define CESR_PAR_BTC 7
`define CESR_PAR_HIST 6
`define CESR_PAR_ITAG 5
`define CESR_PAR_IDATA 4
`define CESR_PAR_TLB 3
`define CESR_PAR_DOUTER 2
`define CESR_PAR_DTAG 1
`define CESR_PAR_DDATA 0
`define CESR_ADDR_W 4
`define CESR_OFF_STATUS 4'h0
`define CESR_OFF_MASK 4'h4
`define CESR_OFF_CFG 4'h8
`define CESR_OFF_CORE 4'hc
`define CESR_IRQ_W 3
`define CESR_IRQ_ABORT 0
`define CESR_IRQ_PAR 1
`define CESR_IRQ_SNOOP 2
`define CESR_CFG_W 2
`define CESR_CFG_ENG_PRESENT 0
`define CESR_CFG_ENG_SIMD 1
`define CESR_CFG_RST 2'h3
`define CESR_ENG_PRESENT 1'b1
`define CESR_PARITY_PRESENT 1'b1
`endif

// ---- common/cesr_pkg.sv ----
// types for the cpu error status report block
`include "cesr_consts.svh"
package cesr_pkg;
	typedef struct packed {
		logic irq;
		logic secure;
		logic privileged;
		logic [`CESR_DEF_W-1:0] flags;
		logic [`CESR_PAR_W-1:0] ram_parity;
	} cesr_cpu_stat_t;
	typedef struct packed {
		logic [`CESR_ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} cesr_avm_req_t;
endpackage

// ---- hdl/cesr_top.sv ----
// cpu error status report: registered status, flag and parity outputs
`timescale 1ns/1ns
`include "cesr_consts.svh"
module cesr_top
	import cesr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [`CESR_NUM_CPU*`CESR_EVT_W-1:0] core_event_in,
	input wire logic [`CESR_NUM_CPU-1:0] core_irq_in,
	input wire logic [`CESR_NUM_CPU-1:0] core_secure_in,
	input wire logic [`CESR_NUM_CPU-1:0] core_priv_in,
	input wire logic [`CESR_NUM_CPU*`CESR_FPSTAT_W-1:0] fp_status_control_register,
	input wire logic writeback_abort_in,
	input wire logic [`CESR_NUM_CPU*`CESR_PAR_W-1:0] ram_parity_check,
	input wire logic [`CESR_NUM_CPU*4-1:0] snoop_tag_parity_check,
	input wire logic [`CESR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [`CESR_NUM_CPU*`CESR_EVT_W-1:0] perf_event_bus,
	output logic [`CESR_NUM_CPU-1:0] metrics_irq,
	output logic [`CESR_NUM_CPU-1:0] cpu_secure_state,
	output logic [`CESR_NUM_CPU-1:0] cpu_privileged_state,
	output logic [`CESR_NUM_CPU*`CESR_DEF_W-1:0] data_engine_flags,
	output logic writeback_abort_pulse,
	output logic [`CESR_NUM_CPU*`CESR_PAR_W-1:0] ram_parity_fail,
	output logic [`CESR_NUM_CPU-1:0] snoop_tag_parity_fail,
	output logic irq
);
	localparam int NC = `CESR_NUM_CPU;
	localparam int PW = `CESR_PAR_W;
	localparam int DW = `CESR_DEF_W;
	localparam int FW = `CESR_FPSTAT_W;

	cesr_avm_req_t req;
	logic [`CESR_CFG_W-1:0] cfg_r;
	logic [`CESR_IRQ_W-1:0] status_r;
	logic [`CESR_IRQ_W-1:0] status_nxt;
	logic [`CESR_IRQ_W-1:0] mask_r;
	logic [`CESR_IRQ_W-1:0] event_set;
	logic ack_r;
	logic [NC*PW-1:0] par_nxt;
	logic [NC-1:0] snoop_nxt;
	logic [NC*DW-1:0] def_nxt;

	assign req = '{address: avs_address, read: avs_read, write: avs_write,
		writedata: avs_writedata};

	// ------------------------------------------------------------
	// per-processor status outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			perf_event_bus <= '0;
			metrics_irq <= '0;
			cpu_secure_state <= '0;
			cpu_privileged_state <= '0;
		end else begin
			perf_event_bus <= core_event_in;
			metrics_irq <= core_irq_in;
			cpu_secure_state <= core_secure_in;
			cpu_privileged_state <= core_priv_in;
		end
	end

	// ------------------------------------------------------------
	// data engine flags
	// ------------------------------------------------------------
	always_comb begin
		def_nxt = '0;
		for (int i = 0; i < NC; i++) begin
			if (`CESR_ENG_PRESENT && cfg_r[`CESR_CFG_ENG_PRESENT]) begin
				def_nxt[i*DW + `CESR_DEF_QC] = cfg_r[`CESR_CFG_ENG_SIMD] &
					fp_status_control_register[i*FW + `CESR_FPSTAT_QC];
				def_nxt[i*DW + `CESR_DEF_IDC] =
					fp_status_control_register[i*FW + `CESR_FPSTAT_IDC];
				def_nxt[i*DW +: 5] = fp_status_control_register[i*FW +: 5];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_engine_flags <= '0;
		end else begin
			data_engine_flags <= def_nxt;
		end
	end

	// ------------------------------------------------------------
	// one-cycle error pulses
	// ------------------------------------------------------------
	// a check held high for several cycles still reports once per rising edge
	logic [NC*PW-1:0] par_prev_r;
	logic [NC-1:0] snoop_prev_r;
	logic abort_prev_r;
	logic [NC-1:0] snoop_or;

	always_comb begin
		snoop_or = '0;
		for (int i = 0; i < NC; i++) begin
			snoop_or[i] = |snoop_tag_parity_check[i*4 +: 4];
		end
	end

	// bit order of each processor vector follows the array mapping
	assign par_nxt = `CESR_PARITY_PRESENT ? (ram_parity_check & ~par_prev_r) : '0;
	assign snoop_nxt = `CESR_PARITY_PRESENT ? (snoop_or & ~snoop_prev_r) : '0;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			par_prev_r <= '0;
			snoop_prev_r <= '0;
			abort_prev_r <= 1'b0;
			ram_parity_fail <= '0;
			snoop_tag_parity_fail <= '0;
			writeback_abort_pulse <= 1'b0;
		end else begin
			par_prev_r <= ram_parity_check;
			snoop_prev_r <= snoop_or;
			abort_prev_r <= writeback_abort_in;
			ram_parity_fail <= par_nxt;
			snoop_tag_parity_fail <= snoop_nxt;
			writeback_abort_pulse <= writeback_abort_in & ~abort_prev_r;
		end
	end

	// ------------------------------------------------------------
	// sticky event status and interrupt
	// ------------------------------------------------------------
	// is met on chip by these sticky flags
	assign event_set[`CESR_IRQ_ABORT] = writeback_abort_pulse;
	assign event_set[`CESR_IRQ_PAR] = |ram_parity_fail;
	assign event_set[`CESR_IRQ_SNOOP] = |snoop_tag_parity_fail;

	always_comb begin
		status_nxt = status_r;
		if (ack_r && req.write && req.address == `CESR_OFF_STATUS) begin
			status_nxt = status_nxt & ~req.writedata[`CESR_IRQ_W-1:0];
		end
		// set wins over clear
		status_nxt = status_nxt | event_set;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_nxt & mask_r);
		end
	end

	// ------------------------------------------------------------
	// avalon-mm slave, one wait state per access
	// ------------------------------------------------------------
	assign avs_waitrequest = (req.read | req.write) & ~ack_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (req.read | req.write) & ~ack_r;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask_r <= '0;
			cfg_r <= `CESR_CFG_RST;
		end else if (req.write && ack_r) begin
			// writes land on the completion edge, like the status clear
			case (req.address)
				`CESR_OFF_MASK: mask_r <= req.writedata[`CESR_IRQ_W-1:0];
				`CESR_OFF_CFG: cfg_r <= req.writedata[`CESR_CFG_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (req.read && !ack_r) begin
			case (req.address)
				`CESR_OFF_STATUS: avs_readdata <= {29'h0, status_r};
				`CESR_OFF_MASK: avs_readdata <= {29'h0, mask_r};
				`CESR_OFF_CFG: avs_readdata <= {30'h0, cfg_r};
				`CESR_OFF_CORE: avs_readdata <= {24'h0, cpu_privileged_state,
					cpu_secure_state};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence abort_rise_s;
		writeback_abort_in && !abort_prev_r;
	endsequence

	property abort_pulse_p;
		@(posedge sys_clk) disable iff (rst)
		abort_rise_s |=> writeback_abort_pulse ##1 !writeback_abort_pulse;
	endproperty

	abort_pulse_a: assert property (abort_pulse_p) else $error("abort pulse wrong");

	abort_single_a: assert property (@(posedge sys_clk) disable iff (rst)
		writeback_abort_pulse |=> !writeback_abort_pulse)
		else $error("abort pulse too long");

	par_single_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ram_parity_fail & $past(ram_parity_fail)) == '0)
		else $error("parity pulse too long");

	// the edge right after reset release still shows the reset values
	par_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |->
		ram_parity_fail == ($past(ram_parity_check) & ~$past(par_prev_r)))
		else $error("parity fail without cause");

	snoop_single_a: assert property (@(posedge sys_clk) disable iff (rst)
		(snoop_tag_parity_fail & $past(snoop_tag_parity_fail)) == '0)
		else $error("snoop tag pulse too long");

	event_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> perf_event_bus == $past(core_event_in))
		else $error("event bus not forwarded");

	state_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> (cpu_secure_state == $past(core_secure_in) &&
		cpu_privileged_state == $past(core_priv_in)))
		else $error("state not forwarded");

	irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> metrics_irq == $past(core_irq_in))
		else $error("metrics irq not forwarded");

	flag_hi_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(cfg_r[`CESR_CFG_ENG_SIMD]) |-> data_engine_flags[`CESR_DEF_QC] == 1'b0)
		else $error("flag 6 set without simd");

	flag_low_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) && $past(cfg_r[`CESR_CFG_ENG_PRESENT]) |->
		data_engine_flags[4:0] == $past(fp_status_control_register[4:0]))
		else $error("flags 4 to 0 wrong");

	reset_zero_a: assert property (@(posedge sys_clk)
		rst |=> rst |-> (ram_parity_fail == '0 && !writeback_abort_pulse))
		else $error("outputs not zero in reset");
endmodule

// ---- bench/cesr_monitor.sv ----
// receiver model: counts the one-cycle status pulses
`timescale 1ns/1ns
`include "cesr_consts.svh"
module cesr_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic writeback_abort_pulse,
	input wire logic [`CESR_NUM_CPU*`CESR_PAR_W-1:0] ram_parity_fail,
	input wire logic [`CESR_NUM_CPU-1:0] snoop_tag_parity_fail,
	output int abort_seen,
	output int par_seen,
	output int snoop_seen
);
	// looks at every edge so that no single-cycle pulse escapes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			abort_seen <= 0;
			par_seen <= 0;
			snoop_seen <= 0;
		end else begin
			abort_seen <= abort_seen + int'(writeback_abort_pulse);
			par_seen <= par_seen + $countones(ram_parity_fail);
			snoop_seen <= snoop_seen + $countones(snoop_tag_parity_fail);
		end
	end
endmodule

// ---- bench/cpu_error_status_report_tb.sv ----
// self-checking bench for the cpu error status report block
`timescale 1ns/1ns
`include "cesr_consts.svh"
module cpu_error_status_report_tb;
	import cesr_pkg::*;
	localparam int N = `CESR_NUM_CPU;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [N*58-1:0] ev = '0;
	logic [N-1:0] cirq = '0, csec = '0, cprv = '0;
	logic [N*32-1:0] fp = '0;
	logic wb = 1'b0;
	logic [N*8-1:0] rpc = '0;
	logic [N*4-1:0] stc = '0;
	cesr_avm_req_t req = '0;
	logic [31:0] rd, q;
	logic wreq, wbp, irq;
	logic [N*58-1:0] peb;
	logic [N-1:0] mirq, sec, prv, stp;
	logic [N*7-1:0] def;
	logic [N*8-1:0] rpf;
	int abort_seen, par_seen, snoop_seen, err_count = 0, comparisons = 0, cyc = 0;
	int cfgs[3] = '{3, 1, 0};
	logic [N*8-1:0] rm;
	logic [N*4-1:0] sm;
	logic sany = 1'b0;

	cesr_top cesr_top_inst (.sys_clk(sys_clk), .rst(rst), .core_event_in(ev),
		.core_irq_in(cirq), .core_secure_in(csec), .core_priv_in(cprv),
		.fp_status_control_register(fp), .writeback_abort_in(wb), .ram_parity_check(rpc),
		.snoop_tag_parity_check(stc), .avs_address(req.address), .avs_read(req.read),
		.avs_write(req.write), .avs_writedata(req.writedata), .avs_readdata(rd),
		.avs_waitrequest(wreq), .perf_event_bus(peb), .metrics_irq(mirq),
		.cpu_secure_state(sec), .cpu_privileged_state(prv), .data_engine_flags(def),
		.writeback_abort_pulse(wbp), .ram_parity_fail(rpf), .snoop_tag_parity_fail(stp),
		.irq(irq));
	cesr_monitor cesr_monitor_inst (.sys_clk(sys_clk), .rst(rst),
		.writeback_abort_pulse(wbp), .ram_parity_fail(rpf), .snoop_tag_parity_fail(stp),
		.abort_seen(abort_seen), .par_seen(par_seen), .snoop_seen(snoop_seen));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{address: a, read: !wr, write: wr, writedata: d};
		// this wait ends once waitrequest reads low; the bench timeout bounds it
		do begin
			@(posedge sys_clk);
		end while (wreq !== 1'b0);
		q = rd;
		req <= '0;
	endtask
	task automatic levels();
		for (int i = 0; i < N; i++) begin
			ev[i*58+:58] <= 58'({$urandom, $urandom});
			fp[i*32+:32] <= $urandom;
		end
		cirq <= N'($urandom);
		csec <= N'($urandom);
		cprv <= N'($urandom);
	endtask
	task automatic hit(input logic a);
		int a0, p0, s0;
		logic [N-1:0] sor;
		a0 = abort_seen;
		p0 = par_seen;
		s0 = snoop_seen;
		for (int i = 0; i < N; i++) sor[i] = |sm[i*4+:4];
		@(posedge sys_clk);
		rpc <= rm;
		stc <= sm;
		wb <= a;
		@(posedge sys_clk);
		#1;
		check(rpf, rm);
		check(stp, sor);
		check(wbp, a);
		repeat (4) @(posedge sys_clk);
		rpc <= '0;
		stc <= '0;
		wb <= 1'b0;
		@(posedge sys_clk);
		#1;
		check(abort_seen - a0, a);
		check(par_seen - p0, $countones(rm));
		check(snoop_seen - s0, $countones(sor));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(73));
		repeat (8) @(posedge sys_clk);
		levels();
		repeat (8) @(posedge sys_clk);
		check({|peb, mirq, sec, prv, |def, wbp, rpf, stp, irq}, 0);
		rst <= 1'b0;
		foreach (cfgs[c]) begin
			bus(1'b1, `CESR_OFF_CFG, cfgs[c]);
			repeat (6) begin
				@(posedge sys_clk);
				levels();
				@(posedge sys_clk);
				#1;
				check(mirq, cirq);
				check(sec, csec);
				check(prv, cprv);
				for (int i = 0; i < N; i++) begin
					check(peb[i*58+:58], ev[i*58+:58]);
					check(def[i*7+:7], cfgs[c][0] ? {cfgs[c][1] & fp[i*32+27],
						fp[i*32+7], fp[i*32+:5]} : 7'h00);
				end
			end
			bus(1'b0, `CESR_OFF_CORE, 0);
			check(q[7:0], {cprv, csec});
		end
		bus(1'b1, `CESR_OFF_STATUS, 32'h7);
		bus(1'b1, `CESR_OFF_MASK, 32'h0);
		for (int k = 0; k < 4; k++) begin
			rm = $urandom | 32'h1;
			sm = 16'($urandom);
			sany = sany | (|sm);
			hit(k[0]);
		end
		check(irq, 1'b0);
		bus(1'b0, `CESR_OFF_STATUS, 0);
		check(q, {29'h0, sany, 1'b1, 1'b1});
		bus(1'b1, 4'h6, 32'h7);
		bus(1'b0, 4'h2, 0);
		check(q, 0);
		bus(1'b1, `CESR_OFF_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		#1;
		check(irq, 1'b1);
		bus(1'b1, `CESR_OFF_STATUS, 32'h1);
		repeat (2) @(posedge sys_clk);
		#1;
		check(irq, 1'b0);
		give_verdict();
	end
endmodule
